// ===== core/fmc_ctrl.sv
// Fiber mode, far-end fault and back-to-back converter control
`timescale 1ns/1ps
module fmc_ctrl (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [2:0] config_strap_i,
    input wire logic far_end_fault_disable_strap_n_i,
    input wire logic [1:0] fiber_signal_detect_in_i,
    input wire logic copper_energy_i,
    input wire logic rmii_txd2_i,
    input wire fmc_pkg::fmc_phy_cfg_t cfg_i,
    output fmc_pkg::fmc_phy_cfg_t phy_cfg_o,
    output fmc_pkg::fmc_strap_t strap_o,
    output logic fiber_mode_o,
    output logic signal_present_o,
    output logic far_end_fault_o,
    output logic rmii_rxd2_o,
    input wire logic link_clk_i,
    input wire logic tx_bit_i,
    input wire logic [1:0] copper_rx_mlt_i,
    input wire logic fiber_rx_bit_i,
    output logic [1:0] copper_tx_mlt_o,
    output logic fiber_tx_bit_o,
    output logic fiber_tx_enable_o,
    output logic rx_bit_o
);
    import fmc_pkg::*;

    localparam int PW = $bits(fmc_pins_t);
    localparam int LW = $bits(fmc_link_ctl_t);

    function automatic logic [1:0] mlt_level(input logic [1:0] idx);
        case (idx)
            2'h1: mlt_level = MLT_PLUS;
            2'h3: mlt_level = MLT_MINUS;
            default: mlt_level = MLT_ZERO;
        endcase
    endfunction : mlt_level

    // ---------------- System domain ----------------
    // Pins pass two flops; the first stage feeds only the second
    fmc_pins_t pins_raw;
    logic [PW-1:0] pin_s1_r;
    logic [PW-1:0] pin_s2_r;
    fmc_pins_t pins;

    assign pins_raw = '{sd: fiber_signal_detect_in_i, energy: copper_energy_i,
                        txd2: rmii_txd2_i};
    assign pins = fmc_pins_t'(pin_s2_r);

    logic [2:0] cfg_s1_r;
    logic [2:0] cfg_s2_r;
    logic fefd_s1_r;
    logic fefd_s2_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            cfg_s1_r <= '0;
            cfg_s2_r <= '0;
            fefd_s1_r <= 1'b1;
            fefd_s2_r <= 1'b1;
        end else if (ce_i) begin
            pin_s1_r <= pins_raw;
            pin_s2_r <= pin_s1_r;
            cfg_s1_r <= config_strap_i;
            cfg_s2_r <= cfg_s1_r;
            fefd_s1_r <= far_end_fault_disable_strap_n_i;
            fefd_s2_r <= fefd_s1_r;
        end
    end

    fmc_state_t state_r;
    fmc_state_t state_nxt;
    logic [1:0] wait_r;
    logic [1:0] wait_nxt;
    fmc_strap_t strap_r;
    fmc_strap_t strap_nxt;

    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        strap_nxt = strap_r;
        if (ce_i) begin
            case (state_r)
                ST_STRAP: begin
                    // Straps sampled once synchronisers hold real pin levels
                    if (wait_r == STRAP_WAIT) begin
                        strap_nxt.b2b_mii = (cfg_s2_r == CFG_MII_B2B);
                        strap_nxt.b2b_rmii = (cfg_s2_r == CFG_RMII_B2B);
                        strap_nxt.fef_en = fefd_s2_r;
                        state_nxt = ST_COPPER;
                    end else begin
                        wait_nxt = wait_r + 2'h1;
                    end
                end
                ST_COPPER, ST_FIB_NOSIG, ST_FIB_SIG: begin
                    case (pins.sd)
                        SD_COPPER: state_nxt = ST_COPPER;
                        SD_SIGNAL: state_nxt = ST_FIB_SIG;
                        default: state_nxt = ST_FIB_NOSIG;
                    endcase
                end
                default: state_nxt = ST_STRAP;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_STRAP;
            wait_r <= 2'h0;
            strap_r <= '0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            strap_r <= strap_nxt;
        end
    end

    logic fiber;
    logic b2b;
    assign fiber = (state_r == ST_FIB_NOSIG) || (state_r == ST_FIB_SIG);
    assign b2b = strap_r.b2b_mii || strap_r.b2b_rmii;

    fmc_phy_cfg_t phy_r;
    fmc_phy_cfg_t phy_nxt;
    logic fef_r;
    logic fef_nxt;
    logic rxd2_r;
    logic rxd2_nxt;
    logic txoff_r;
    logic txoff_nxt;
    // Registered so no decode glitch reaches the link flops
    logic fiber_x_r;
    logic fiber_x_nxt;

    always_comb begin
        phy_nxt = phy_r;
        fef_nxt = fef_r;
        rxd2_nxt = rxd2_r;
        txoff_nxt = txoff_r;
        fiber_x_nxt = fiber_x_r;
        if (ce_i) begin
            phy_nxt = cfg_i;
            if (fiber) begin
                phy_nxt.autoneg = 1'b0;
                phy_nxt.crossover = 1'b0;
                phy_nxt.speed_100 = 1'b1;
            end
            phy_nxt.full_duplex = cfg_i.full_duplex;
            phy_nxt.adv_10 = cfg_i.adv_10 && !(b2b && !fiber);
            fef_nxt = (state_r == ST_FIB_NOSIG) && strap_r.fef_en;
            rxd2_nxt = strap_r.b2b_rmii && !fiber && pins.energy;
            txoff_nxt = strap_r.b2b_rmii && fiber && pins.txd2;
            fiber_x_nxt = fiber;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phy_r <= '0;
            fef_r <= 1'b0;
            rxd2_r <= 1'b0;
            txoff_r <= 1'b0;
            fiber_x_r <= 1'b0;
        end else begin
            phy_r <= phy_nxt;
            fef_r <= fef_nxt;
            rxd2_r <= rxd2_nxt;
            txoff_r <= txoff_nxt;
            fiber_x_r <= fiber_x_nxt;
        end
    end

    assign phy_cfg_o = phy_r;
    assign strap_o = strap_r;
    assign fiber_mode_o = fiber;
    assign signal_present_o = (state_r == ST_FIB_SIG);
    assign far_end_fault_o = fef_r;
    assign rmii_rxd2_o = rxd2_r;

    // ---------------- Link domain ----------------
    // Reset asserts at once, releases on the link clock
    logic lrst_s1_r;
    logic lrst_r;
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lrst_s1_r <= 1'b1;
            lrst_r <= 1'b1;
        end else begin
            lrst_s1_r <= 1'b0;
            lrst_r <= lrst_s1_r;
        end
    end

    // Control levels only; a few link cycles of skew is harmless
    fmc_link_ctl_t ctl_src;
    logic [LW-1:0] ctl_s1_r;
    logic [LW-1:0] ctl_s2_r;
    fmc_link_ctl_t ctl;
    assign ctl_src = '{ce: ce_i, fiber: fiber_x_r, fef: fef_r, tx_off: txoff_r};
    assign ctl = fmc_link_ctl_t'(ctl_s2_r);

    genvar gi;
    generate
        for (gi = 0; gi < LW; gi++) begin : g_ctl_sync
            always_ff @(posedge link_clk_i or posedge lrst_r) begin
                if (lrst_r) begin
                    ctl_s1_r[gi] <= 1'b0;
                    ctl_s2_r[gi] <= 1'b0;
                end else begin
                    ctl_s1_r[gi] <= ctl_src[gi];
                    ctl_s2_r[gi] <= ctl_s1_r[gi];
                end
            end
        end
    endgenerate

    logic fef_bit;
    fmc_fef_gen #(
        .ONES(FEF_ONES),
        .ZEROS(FEF_ZEROS)
    ) u_fef (
        .link_clk_i(link_clk_i),
        .link_rst_i(lrst_r),
        .ce_i(ctl.ce),
        .active_i(ctl.fef),
        .bit_o(fef_bit)
    );

    logic [SCR_LEN-1:0] scr_r;
    logic [SCR_LEN-1:0] scr_nxt;
    logic [SCR_LEN-1:0] dsc_r;
    logic [SCR_LEN-1:0] dsc_nxt;
    logic [1:0] mtx_idx_r;
    logic [1:0] mtx_idx_nxt;
    logic [1:0] mrx_prev_r;
    logic [1:0] mrx_prev_nxt;
    logic [1:0] ctx_r;
    logic [1:0] ctx_nxt;
    logic ftx_r;
    logic ftx_nxt;
    logic fen_r;
    logic fen_nxt;
    logic rxb_r;
    logic rxb_nxt;
    logic scr_fb;
    logic dsc_fb;
    logic rx_scr;

    always_comb begin
        scr_nxt = scr_r;
        dsc_nxt = dsc_r;
        mtx_idx_nxt = mtx_idx_r;
        mrx_prev_nxt = mrx_prev_r;
        ctx_nxt = ctx_r;
        ftx_nxt = ftx_r;
        fen_nxt = fen_r;
        rxb_nxt = rxb_r;
        scr_fb = scr_r[SCR_TAP_A] ^ scr_r[SCR_TAP_B];
        dsc_fb = dsc_r[SCR_TAP_A] ^ dsc_r[SCR_TAP_B];
        rx_scr = (copper_rx_mlt_i != mrx_prev_r);
        if (ctl.ce) begin
            if (ctl.fiber) begin
                ftx_nxt = ctl.fef ? fef_bit : tx_bit_i;
                rxb_nxt = fiber_rx_bit_i;
                ctx_nxt = MLT_ZERO;
            end else begin
                scr_nxt = {scr_r[SCR_LEN-2:0], scr_fb};
                if (tx_bit_i ^ scr_fb) begin
                    mtx_idx_nxt = mtx_idx_r + 2'h1;
                end
                ctx_nxt = mlt_level(mtx_idx_nxt);
                // Self-synchronising, so no seed alignment with the far end
                dsc_nxt = {dsc_r[SCR_LEN-2:0], rx_scr};
                rxb_nxt = rx_scr ^ dsc_fb;
                ftx_nxt = 1'b0;
            end
            mrx_prev_nxt = copper_rx_mlt_i;
            fen_nxt = ctl.fiber && !ctl.tx_off;
        end
    end

    always_ff @(posedge link_clk_i or posedge lrst_r) begin
        if (lrst_r) begin
            scr_r <= SCR_SEED;
            dsc_r <= '0;
            mtx_idx_r <= 2'h0;
            mrx_prev_r <= MLT_ZERO;
            ctx_r <= MLT_ZERO;
            ftx_r <= 1'b0;
            fen_r <= 1'b0;
            rxb_r <= 1'b0;
        end else begin
            scr_r <= scr_nxt;
            dsc_r <= dsc_nxt;
            mtx_idx_r <= mtx_idx_nxt;
            mrx_prev_r <= mrx_prev_nxt;
            ctx_r <= ctx_nxt;
            ftx_r <= ftx_nxt;
            fen_r <= fen_nxt;
            rxb_r <= rxb_nxt;
        end
    end

    assign copper_tx_mlt_o = ctx_r;
    assign fiber_tx_bit_o = ftx_r;
    assign fiber_tx_enable_o = fen_r;
    assign rx_bit_o = rxb_r;
endmodule : fmc_ctrl

// ===== core/fmc_fef_gen.sv
// Far-end fault pattern generator on the link clock
`timescale 1ns/1ps
module fmc_fef_gen #(
    parameter int ONES = fmc_pkg::FEF_ONES,
    parameter int ZEROS = fmc_pkg::FEF_ZEROS
) (
    input wire logic link_clk_i,
    input wire logic link_rst_i,
    input wire logic ce_i,
    input wire logic active_i,
    output logic bit_o
);
    import fmc_pkg::*;
    localparam int PERIOD = ONES + ZEROS;
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    localparam logic [CW-1:0] ONES_W = CW'(ONES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic bit_r;
    logic bit_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        if (ce_i) begin
            if (!active_i) begin
                // Held one is the first of the run, so count on from one
                cnt_nxt = CW'(1);
                bit_nxt = 1'b1;
            end else begin
                cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
                bit_nxt = (cnt_r < ONES_W);
            end
        end
    end

    always_ff @(posedge link_clk_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            cnt_r <= CW'(1);
            bit_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign bit_o = bit_r;
endmodule : fmc_fef_gen

// ===== core/fmc_pkg.sv
// Shared constants and types for the fiber mode and media converter control
package fmc_pkg;
    // Configuration strap codes
    localparam logic [2:0] CFG_MII_B2B = 3'h6;
    localparam logic [2:0] CFG_RMII_B2B = 3'h5;
    // Signal detect comparator codes {above_2v2, above_1v}
    localparam logic [1:0] SD_COPPER = 2'h0;
    localparam logic [1:0] SD_NO_SIGNAL = 2'h1;
    localparam logic [1:0] SD_SIGNAL = 2'h3;
    // Fault pattern: ones then zeros
    localparam int FEF_ONES = 84;
    localparam int FEF_ZEROS = 1;
    // Scrambler polynomial x^11 + x^9 + 1
    localparam int SCR_LEN = 11;
    localparam int SCR_TAP_A = 10;
    localparam int SCR_TAP_B = 8;
    localparam logic [10:0] SCR_SEED = 11'h7FF;
    // Three-level line codes
    localparam logic [1:0] MLT_ZERO = 2'h0;
    localparam logic [1:0] MLT_PLUS = 2'h1;
    localparam logic [1:0] MLT_MINUS = 2'h3;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef enum logic [3:0] {
        ST_STRAP = 4'h1,
        ST_COPPER = 4'h2,
        ST_FIB_NOSIG = 4'h4,
        ST_FIB_SIG = 4'h8
    } fmc_state_t;

    typedef struct packed {
        logic autoneg;
        logic crossover;
        logic speed_100;
        logic full_duplex;
        logic adv_10;
    } fmc_phy_cfg_t;

    typedef struct packed {
        logic b2b_mii;
        logic b2b_rmii;
        logic fef_en;
    } fmc_strap_t;

    typedef struct packed {
        logic ce;
        logic fiber;
        logic fef;
        logic tx_off;
    } fmc_link_ctl_t;

    typedef struct packed {
        logic [1:0] sd;
        logic energy;
        logic txd2;
    } fmc_pins_t;
endpackage : fmc_pkg

// ===== sim/fmc_ctrl_checker.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
module fmc_ctrl_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic rmii_txd2_i,
    input wire fmc_pkg::fmc_phy_cfg_t cfg_i,
    input wire fmc_pkg::fmc_phy_cfg_t phy_cfg_o,
    input wire fmc_pkg::fmc_strap_t strap_o,
    input wire logic fiber_mode_o,
    input wire logic signal_present_o,
    input wire logic far_end_fault_o,
    input wire logic rmii_rxd2_o,
    input wire logic link_clk_i,
    input wire logic fiber_tx_bit_o,
    input wire logic fiber_tx_enable_o
);
    import fmc_pkg::*;
    logic [7:0] ones_r;
    logic [7:0] ones_nxt;
    // Saturates so a stuck line cannot wrap into a match
    always_comb begin
        ones_nxt = 8'h00;
        if (fiber_tx_bit_o) begin
            ones_nxt = (ones_r == 8'hFF) ? ones_r : ones_r + 8'h01;
        end
    end
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ones_r <= 8'h00;
        end else begin
            ones_r <= ones_nxt;
        end
    end
    sequence s_fault_end;
        far_end_fault_o && $past(far_end_fault_o, 100) && $fell(fiber_tx_bit_o);
    endsequence
    sequence s_b2b_copper;
        ((strap_o.b2b_mii || strap_o.b2b_rmii) && !fiber_mode_o) [*4];
    endsequence
    chk_fiber_cfg_forced: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fiber_mode_o && $past(fiber_mode_o) |->
        !phy_cfg_o.autoneg && !phy_cfg_o.crossover && phy_cfg_o.speed_100)
        else $error("fiber config not forced");
    chk_duplex_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        fiber_mode_o && $past(ce_i) |-> phy_cfg_o.full_duplex == $past(cfg_i.full_duplex))
        else $error("duplex not passed");
    chk_signal_in_fiber: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        signal_present_o |-> fiber_mode_o)
        else $error("signal outside fiber");
    chk_fault_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $past(ce_i) |-> far_end_fault_o ==
        ($past(fiber_mode_o) && !$past(signal_present_o) && $past(strap_o.fef_en)))
        else $error("fault level wrong");
    chk_fault_run: assert property (@(posedge link_clk_i) disable iff (rst_i)
        s_fault_end |-> ones_r == FEF_ONES)
        else $error("fault ones run wrong");
    chk_fault_one_zero: assert property (@(posedge link_clk_i) disable iff (rst_i)
        s_fault_end |=> fiber_tx_bit_o)
        else $error("fault zero run wrong");
    chk_strap_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        strap_o != 3'h0 |=> $stable(strap_o) && !(strap_o.b2b_mii && strap_o.b2b_rmii))
        else $error("strap changed");
    chk_adv10_blocked: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_b2b_copper |-> !phy_cfg_o.adv_10)
        else $error("10M offered");
    chk_energy_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        rmii_rxd2_o |-> strap_o.b2b_rmii && !$past(fiber_mode_o))
        else $error("energy out of mode");
    chk_tx_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(strap_o.b2b_rmii && fiber_mode_o && rmii_txd2_i) |-> ##[1:60] !fiber_tx_enable_o)
        else $error("transmitter not off");
endmodule : fmc_ctrl_checker
bind fmc_ctrl fmc_ctrl_checker fmc_ctrl_checker_inst (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .rmii_txd2_i(rmii_txd2_i),
    .cfg_i(cfg_i),
    .phy_cfg_o(phy_cfg_o),
    .strap_o(strap_o),
    .fiber_mode_o(fiber_mode_o),
    .signal_present_o(signal_present_o),
    .far_end_fault_o(far_end_fault_o),
    .rmii_rxd2_o(rmii_rxd2_o),
    .link_clk_i(link_clk_i),
    .fiber_tx_bit_o(fiber_tx_bit_o),
    .fiber_tx_enable_o(fiber_tx_enable_o)
);

// ===== sim/fmc_fiber_model.sv
// Fiber optical module model: signal detect code and receive bit stream
`timescale 1ns/1ps
module fmc_fiber_model (
    input wire logic link_clk_i,
    input wire logic [1:0] sd_sel_i,
    output logic [1:0] sd_o,
    output logic rx_bit_o
);
    import fmc_pkg::*;
    logic [4:0] lfsr_r = 5'h1F;
    initial begin
        sd_o = SD_COPPER;
        rx_bit_o = 1'b0;
    end
    always @(posedge link_clk_i) begin
        sd_o <= sd_sel_i;
        lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
        // No signal gives a toggling bit, never a held level
        rx_bit_o <= (sd_o == SD_SIGNAL) ? lfsr_r[4] : ~rx_bit_o;
    end
endmodule : fmc_fiber_model

// ===== sim/testbench.sv
// Self-checking bench for fiber mode and converter control
`timescale 1ns/1ps
module testbench;
    import fmc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [2:0] config_strap_i = 3'h0;
    logic far_end_fault_disable_strap_n_i = 1'b1;
    logic [1:0] sd_sel = 2'h0;
    logic [1:0] fiber_signal_detect_in_i;
    logic copper_energy_i = 1'b0;
    logic rmii_txd2_i = 1'b0;
    fmc_phy_cfg_t cfg_i = 5'h1B;
    fmc_phy_cfg_t phy_cfg_o;
    fmc_strap_t strap_o;
    logic fiber_mode_o, signal_present_o, far_end_fault_o, rmii_rxd2_o;
    logic tx_bit_i = 1'b0;
    logic tx_prev = 1'b0;
    logic rx_prev = 1'b0;
    logic [1:0] copper_rx_mlt_i = 2'h0;
    logic fiber_rx_bit_i;
    logic [1:0] copper_tx_mlt_o;
    logic fiber_tx_bit_o, fiber_tx_enable_o, rx_bit_o;
    logic [2:0] lcnt = 3'h0;
    int err_total = 0;
    int num_checks = 0;

    fmc_ctrl fmc_ctrl_inst (.*);
    fmc_fiber_model fmc_fiber_model_inst (
        .link_clk_i(link_clk_i),
        .sd_sel_i(sd_sel),
        .sd_o(fiber_signal_detect_in_i),
        .rx_bit_o(fiber_rx_bit_i)
    );

    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #3;
        forever #16 link_clk_i = ~link_clk_i;
    end
    always @(posedge link_clk_i) begin
        lcnt <= lcnt + 3'h1;
        tx_bit_i <= lcnt[2] ^ lcnt[0];
        tx_prev <= tx_bit_i;
        rx_prev <= fiber_rx_bit_i;
        copper_rx_mlt_i <= lcnt[0] ? MLT_PLUS : (lcnt[1] ? MLT_MINUS : MLT_ZERO);
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : w
    task automatic restart(input logic [2:0] strap, input logic fef_n);
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        config_strap_i <= strap;
        far_end_fault_disable_strap_n_i <= fef_n;
        sd_sel <= SD_COPPER;
        w(12);
        rst_i <= 1'b0;
        w(20);
    endtask : restart
    task automatic set_sd(input logic [1:0] code);
        sd_sel <= code;
        w(40);
    endtask : set_sd
    task automatic fault_runs();
        int n;
        n = 0;
        do begin
            @(negedge link_clk_i);
            n++;
        end while (fiber_tx_bit_o !== 1'b0 && n < 300);
        repeat (2) begin
            n = 0;
            @(negedge link_clk_i);
            while (fiber_tx_bit_o === 1'b1 && n < 100) begin
                n++;
                @(negedge link_clk_i);
            end
            chk("ones", 8'(n), 8'(FEF_ONES));
        end
        @(posedge sys_clk_i);
    endtask : fault_runs
    task automatic bypass(input int n);
        repeat (n) begin
            @(negedge link_clk_i);
            chk("tx bit", 8'(fiber_tx_bit_o), 8'(tx_prev));
            chk("rx bit", 8'(rx_bit_o), 8'(rx_prev));
            chk("mlt", 8'(copper_tx_mlt_o), 8'(MLT_ZERO));
        end
        @(posedge sys_clk_i);
    endtask : bypass

    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        restart(CFG_MII_B2B, 1'b1);
        chk("strap", 8'(strap_o), 8'h05);
        set_sd(SD_COPPER);
        chk("cfg", 8'(phy_cfg_o), 8'h1A);
        chk("txen", 8'(fiber_tx_enable_o), 8'h00);
        set_sd(SD_NO_SIGNAL);
        chk("mode", 8'({fiber_mode_o, signal_present_o, far_end_fault_o}), 8'h05);
        chk("cfg", 8'(phy_cfg_o), 8'h07);
        cfg_i <= 5'h19;
        w(4);
        chk("cfg", 8'(phy_cfg_o), 8'h05);
        fault_runs();
        chk("txen", 8'(fiber_tx_enable_o), 8'h01);
        set_sd(2'h2);
        chk("mode", 8'({fiber_mode_o, signal_present_o, far_end_fault_o}), 8'h05);
        set_sd(SD_SIGNAL);
        chk("mode", 8'({fiber_mode_o, signal_present_o, far_end_fault_o}), 8'h06);
        bypass(40);
        restart(CFG_RMII_B2B, 1'b0);
        chk("strap", 8'(strap_o), 8'h02);
        ce_i <= 1'b0;
        set_sd(SD_NO_SIGNAL);
        chk("frozen", 8'(fiber_mode_o), 8'h00);
        ce_i <= 1'b1;
        w(10);
        chk("mode", 8'({fiber_mode_o, signal_present_o, far_end_fault_o}), 8'h04);
        set_sd(SD_COPPER);
        for (int e = 0; e < 2; e++) begin
            copper_energy_i <= e[0];
            // peer bit 2 fed with inverted energy
            rmii_txd2_i <= ~e[0];
            w(12);
            chk("rxd2", 8'(rmii_rxd2_o), 8'(e[0]));
        end
        set_sd(SD_SIGNAL);
        chk("rxd2", 8'(rmii_rxd2_o), 8'h00);
        chk("txen", 8'(fiber_tx_enable_o), 8'h01);
        rmii_txd2_i <= 1'b1;
        w(60);
        chk("txen", 8'(fiber_tx_enable_o), 8'h00);
        rmii_txd2_i <= 1'b0;
        w(60);
        chk("txen", 8'(fiber_tx_enable_o), 8'h01);
        restart(3'h0, 1'b1);
        set_sd(SD_COPPER);
        chk("strap", 8'(strap_o), 8'h01);
        chk("cfg", 8'(phy_cfg_o), 8'h19);
        end_sim();
    end
endmodule : testbench
